// File: src/mw_cfg.svh
// register fields, reset values and timing counts of the word serial channel
`ifndef MW_CFG_SVH
`define MW_CFG_SVH
`define MW_CMR_POL 12
`define MW_CMR_EXT 8
`define MW_MODE_EN 1
`define MW_MODE_GATE 0
`define MW_LEN_HI 7
`define MW_LEN_LO 5
`define MW_LEN8 3'h0
`define MW_CCR_TSB 15
`define MW_CCR_TSB2 14
`define MW_TIC_WAIT 2
`define MW_TCS_MARK 8
`define MW_HCR_RECEIVE_DMA_ACKNOWLEDGE 0
`define MW_HCR_TRANSMIT_DMA_ACKNOWLEDGE 4
`define MW_HCR_DPLL_HI 9
`define MW_HCR_DPLL_LO 8
`define MW_HCR_CVOK 10
`define MW_DPLL_BIPH 2'h3
`define MW_IOC_RECEIVE_DMA_REQUEST 0
`define MW_IOC_TRANSMIT_DMA_REQUEST 1
`define MW_IOC_TXC 2
`define MW_IOC_TXD 3
`define MW_ICR_MIE 15
`define MW_RIC_PE_IE 4
`define MW_RIC_OV_IE 5
`define MW_RCS_POL 8
`define MW_RCS_PE 9
`define MW_RCS_OV 10
`define MW_ORDER_RST 2'h0
`define MW_BIT_RATE_HZ 1000000
`define MW_RXC_HZ 8000000
`define MW_BIT_TICKS (`MW_RXC_HZ / `MW_BIT_RATE_HZ)
`define MW_SYNC_MIN 5'd11
`define MW_FIRST_SMP 8'd14
`define MW_SMP_PHASE 3'h6
`define MW_RC_MAX 5'd31
`define MW_FIFO_BYTES 6'd32
`endif

// File: src/mw_channel.sv
// one word serial channel: manchester framer, byte fifos, dma requests
`timescale 1ns/1ps
`default_nettype none
`include "mw_cfg.svh"
module mw_channel
  import mw_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  // configuration registers
  input  wire logic [15:0] channel_mode_reg_i,
  input  wire logic        channel_mode_wr_i,
  input  wire logic [15:0] channel_control_reg_i,
  input  wire logic [15:0] receive_mode_reg_i,
  input  wire logic [15:0] transmit_mode_reg_i,
  input  wire logic [15:0] transmit_irq_control_reg_i,
  input  wire logic [15:0] transmit_command_status_reg_i,
  input  wire logic [15:0] receive_irq_control_reg_i,
  input  wire logic [15:0] interrupt_control_reg_i,
  input  wire logic [15:0] hardware_config_reg_i,
  input  wire logic [15:0] pin_control_reg_i,
  input  wire logic        clock_connect_i,
  // channel commands
  input  wire logic        order_cmd_i,
  input  wire logic [1:0]  order_i,
  input  wire logic        send_cmd_i,
  input  wire logic        send_count_load_i,
  input  wire logic [15:0] send_count_i,
  input  wire logic        irq_clear_i,
  // transmit data port
  input  wire logic        tx_wr_i,
  input  wire logic        tx_wide_i,
  input  wire logic [15:0] tx_data_i,
  output logic             tx_room_o,
  output logic             tx_need_status_o,
  // receive data port
  input  wire logic        rx_rd_i,
  output logic             rx_valid_o,
  output logic [7:0]       rx_data_o,
  output logic             rx_eof_o,
  output logic [15:0]      receive_command_status_reg_o,
  output logic             irq_o,
  // dma pins
  output logic             receive_dma_request_n_o,
  output logic             transmit_dma_request_n_o,
  input  wire logic        receive_dma_acknowledge_n_i,
  input  wire logic        transmit_dma_acknowledge_n_i,
  // serial pins
  input  wire logic        receive_clock_pin_i,
  input  wire logic        rx_data_pin_i,
  input  wire logic        carrier_detect_n_i,
  input  wire logic        clear_to_send_n_i,
  output logic             tx_data_pin_o,
  output logic             tx_data_pin_oe_o,
  output logic             transmit_clock_pin_o,
  output logic             transmit_clock_pin_oe_o
);
  import mw_pkg::*;

  mw_state_type s_ff, nxt_s;
  logic [10:0] rx_mem [0:31];
  logic [9:0]  tx_mem [0:31];
  logic        rx_push, tx_push, tx_push2;
  logic [10:0] rx_e0, rx_e1;
  logic [9:0]  tx_e0, tx_e1;
  logic        tk, rx_on, tx_on, word_mode, dpll_ok, tx_wr, rx_rd, tx_want;
  logic [5:0]  rx_used, tx_used;

  // serial position k to bus bit under each ordering
  function automatic logic [3:0] bus_bit(input logic [1:0] o, input logic [3:0] k);
    case (o)
      2'h0:    bus_bit = k + 4'h8;
      2'h1:    bus_bit = 4'hf - k;
      2'h2:    bus_bit = k;
      default: bus_bit = 4'h7 - k;
    endcase
  endfunction : bus_bit

  // half-bit pattern, first half-bit in the top bit
  function automatic logic [39:0] frame(input logic [1:0] o, input logic [15:0] w,
                                        input logic p);
    logic [39:0] f;
    logic        b;
    f = {p ? 6'b111000 : 6'b000111, 34'h0};
    for (int k = 0; k < 16; k++) begin
      b = w[bus_bit(o, 4'(k))];
      f[33 - 2 * k] = b;
      f[32 - 2 * k] = ~b;
    end
    f[1] = ~^w;
    f[0] = ^w;
    frame = f;
  endfunction : frame

  always_comb begin
    dpll_ok   = (hardware_config_reg_i[`MW_HCR_DPLL_HI:`MW_HCR_DPLL_LO] == `MW_DPLL_BIPH)
                & hardware_config_reg_i[`MW_HCR_CVOK];
    word_mode = channel_mode_reg_i[`MW_CMR_EXT]
                & (receive_mode_reg_i[`MW_LEN_HI:`MW_LEN_LO] == `MW_LEN8)
                & (transmit_mode_reg_i[`MW_LEN_HI:`MW_LEN_LO] == `MW_LEN8);
    rx_on = receive_mode_reg_i[`MW_MODE_EN] & word_mode & dpll_ok
            & (~receive_mode_reg_i[`MW_MODE_GATE] | ~s_ff.st[2]);
    tx_on = transmit_mode_reg_i[`MW_MODE_EN] & word_mode
            & (~transmit_mode_reg_i[`MW_MODE_GATE] | ~s_ff.st[3]);
    // one tick per rising edge of the 8x clock, only once a source is connected
    tk = clock_connect_i & s_ff.st[0] & ~s_ff.rxc_d;
    rx_used = s_ff.rwp - s_ff.rrp;
    tx_used = s_ff.twp - s_ff.trp;
    tx_room_o = (`MW_FIFO_BYTES - tx_used) >= 6'd2;
    tx_wr = tx_wr_i | (hardware_config_reg_i[`MW_HCR_TRANSMIT_DMA_ACKNOWLEDGE] & ~transmit_dma_acknowledge_n_i);
    rx_rd = rx_rd_i | (hardware_config_reg_i[`MW_HCR_RECEIVE_DMA_ACKNOWLEDGE] & ~receive_dma_acknowledge_n_i);
    tx_want = tx_on & ~s_ff.hold & tx_room_o
              & (s_ff.need_st | ~transmit_irq_control_reg_i[`MW_TIC_WAIT] | s_ff.armed);
  end

  always_comb begin
    logic [16:0] fb;
    logic [15:0] w, c1;
    logic        pe, e0, e1, ov_set;
    logic [10:0] h0, h1;
    logic [39:0] fr;
    fb = 17'h0;
    w = 16'h0;
    c1 = 16'h0;
    pe = 1'b0;
    e0 = 1'b0;
    e1 = 1'b0;
    h0 = rx_mem[s_ff.rrp[4:0]];
    h1 = 11'h0;
    fr = 40'h0;
    ov_set = 1'b0;
    nxt_s = s_ff;
    rx_push = 1'b0;
    tx_push = 1'b0;
    tx_push2 = 1'b0;
    rx_e0 = 11'h0;
    rx_e1 = 11'h0;
    tx_e0 = 10'h0;
    tx_e1 = 10'h0;
    // three-stage pin synchroniser; a level counts once stages two and three agree
    nxt_s.s1 = {clear_to_send_n_i, carrier_detect_n_i, rx_data_pin_i, receive_clock_pin_i};
    nxt_s.s2 = s_ff.s1;
    nxt_s.s3 = s_ff.s2;
    nxt_s.st = (s_ff.s2 & s_ff.s3) | (s_ff.st & (s_ff.s2 | s_ff.s3));
    nxt_s.rxc_d = s_ff.st[0];
    nxt_s.order = order_cmd_i ? order_i : s_ff.order;
    // receiver: sync found at the mid-sync edge after 1.5 bit times of one level
    if (tk) begin
      nxt_s.rl_d = s_ff.st[1];
      case (s_ff.rst)
        RX_IDLE: begin
          if (s_ff.st[1] != s_ff.rl_d) begin
            if (rx_on && s_ff.rc >= `MW_SYNC_MIN) begin
              nxt_s.rpol = s_ff.rl_d;
              nxt_s.rst = RX_WORD;
              nxt_s.pc = 8'h0;
              nxt_s.bc = 5'h0;
            end
            nxt_s.rc = 5'h0;
          end else if (s_ff.rc != `MW_RC_MAX) begin
            nxt_s.rc = s_ff.rc + 5'h1;
          end
        end
        RX_WORD: begin
          nxt_s.pc = s_ff.pc + 8'h1;
          // first half of each bit cell carries its value
          if (s_ff.pc >= `MW_FIRST_SMP && s_ff.pc[2:0] == `MW_SMP_PHASE) begin
            nxt_s.sr[s_ff.bc] = s_ff.st[1];
            nxt_s.bc = s_ff.bc + 5'h1;
            if (s_ff.bc == 5'd16) begin
              fb = {s_ff.st[1], s_ff.sr[15:0]};
              for (int k = 0; k < 16; k++) begin
                w[bus_bit(s_ff.order, 4'(k))] = fb[k];
              end
              pe = ~^fb;
              if ((`MW_FIFO_BYTES - rx_used) >= 6'd2) begin
                rx_push = 1'b1;
                rx_e0 = {1'b0, s_ff.rpol, pe, w[7:0]};
                rx_e1 = {1'b1, s_ff.rpol, pe, w[15:8]};
                nxt_s.rwp = s_ff.rwp + 6'd2;
              end else begin
                ov_set = 1'b1;
              end
              nxt_s.rst = RX_IDLE;
              nxt_s.rc = 5'h0;
            end
          end
        end
        default: nxt_s.rst = RX_IDLE;
      endcase
    end
    // receive fifo read; status follows the word once its last byte is read
    if (rx_rd && rx_used != 6'h0) begin
      nxt_s.rdat = h0[7:0];
      nxt_s.reof = h0[10];
      nxt_s.rrp = s_ff.rrp + 6'h1;
      if (h0[10]) begin
        nxt_s.rcs_pol = h0[9];
        nxt_s.rcs_pe = h0[8];
      end
    end
    // event flags: a set in the clearing cycle still wins
    nxt_s.pe_pend = (s_ff.pe_pend & ~irq_clear_i) | pe;
    nxt_s.ov_pend = (s_ff.ov_pend & ~irq_clear_i) | ov_set;
    nxt_s.ovr = (s_ff.ovr & ~irq_clear_i) | ov_set;
    // transmit side
    nxt_s.pol = channel_mode_wr_i ? channel_mode_reg_i[`MW_CMR_POL] : s_ff.pol;
    nxt_s.cnt = send_count_load_i ? send_count_i : s_ff.cnt;
    if (tx_wr && s_ff.need_st) begin
      if (!s_ff.st_idx) begin
        nxt_s.pol = tx_data_i[`MW_CMR_POL];
        nxt_s.st_idx = channel_control_reg_i[`MW_CCR_TSB2];
        nxt_s.need_st = channel_control_reg_i[`MW_CCR_TSB2];
      end else begin
        nxt_s.cnt = tx_data_i;
        nxt_s.st_idx = 1'b0;
        nxt_s.need_st = 1'b0;
      end
    end else if (tx_wr && tx_room_o) begin
      e0 = (s_ff.cnt == 16'h0);
      c1 = e0 ? 16'h0 : s_ff.cnt - 16'h1;
      e1 = (c1 == 16'h0);
      tx_push = 1'b1;
      tx_push2 = tx_wide_i;
      tx_e0 = {e0, s_ff.pol, tx_data_i[7:0]};
      tx_e1 = {e1, s_ff.pol, tx_data_i[15:8]};
      nxt_s.cnt = (tx_wide_i && !e1) ? c1 - 16'h1 : c1;
      nxt_s.twp = s_ff.twp + (tx_wide_i ? 6'd2 : 6'd1);
      if (e0 || (tx_wide_i && e1)) begin
        nxt_s.hold = 1'b1;
        nxt_s.armed = 1'b0;
        nxt_s.need_st = channel_control_reg_i[`MW_CCR_TSB];
      end
    end
    nxt_s.armed = nxt_s.armed | send_cmd_i;
    if (tk) begin
      nxt_s.hc = s_ff.hc + 3'h1;
      case (s_ff.tst)
        TX_IDLE: begin
          // ones idle is high then low per bit; marking holds the line high
          nxt_s.txd = transmit_command_status_reg_i[`MW_TCS_MARK] | ~nxt_s.hc[2];
          if (s_ff.hc == 3'h7 && tx_on && tx_used >= 6'd2) begin
            h0 = {1'b0, tx_mem[s_ff.trp[4:0]]};
            h1 = {1'b0, tx_mem[5'(s_ff.trp[4:0] + 5'h1)]};
            fr = frame(s_ff.order, {h1[7:0], h0[7:0]}, h0[8]);
            nxt_s.pat = {fr[38:0], 1'b0};
            nxt_s.txd = fr[39];
            nxt_s.hn = 6'd1;
            nxt_s.tst = TX_SEND;
            nxt_s.trp = s_ff.trp + 6'd2;
            nxt_s.hold = nxt_s.hold & ~(h0[9] | h1[9]);
          end
        end
        TX_SEND: begin
          if (s_ff.hc[1:0] == 2'h3) begin
            if (s_ff.hn == 6'd40) begin
              nxt_s.tst = TX_IDLE;
              nxt_s.txd = transmit_command_status_reg_i[`MW_TCS_MARK] | ~nxt_s.hc[2];
            end else begin
              nxt_s.txd = s_ff.pat[39];
              nxt_s.pat = {s_ff.pat[38:0], 1'b0};
              nxt_s.hn = s_ff.hn + 6'd1;
            end
          end
        end
        default: nxt_s.tst = TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      s_ff <= '0;
      s_ff.order <= `MW_ORDER_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // byte memories, no reset needed since pointers guard them
  always_ff @(posedge ref_clk_i) begin
    if (rx_push) begin
      rx_mem[s_ff.rwp[4:0]] <= rx_e0;
      rx_mem[5'(s_ff.rwp[4:0] + 5'h1)] <= rx_e1;
    end
    if (tx_push) begin
      tx_mem[s_ff.twp[4:0]] <= tx_e0;
    end
    if (tx_push2) begin
      tx_mem[5'(s_ff.twp[4:0] + 5'h1)] <= tx_e1;
    end
  end

  always_comb begin
    rx_valid_o = (rx_used != 6'h0);
    rx_data_o = s_ff.rdat;
    rx_eof_o = s_ff.reof;
    receive_command_status_reg_o = 16'h0;
    receive_command_status_reg_o[`MW_RCS_POL] = s_ff.rcs_pol;
    receive_command_status_reg_o[`MW_RCS_PE] = s_ff.rcs_pe;
    receive_command_status_reg_o[`MW_RCS_OV] = s_ff.ovr;
    irq_o = interrupt_control_reg_i[`MW_ICR_MIE]
            & ((receive_irq_control_reg_i[`MW_RIC_PE_IE] & s_ff.pe_pend)
            | (receive_irq_control_reg_i[`MW_RIC_OV_IE] & s_ff.ov_pend));
    tx_need_status_o = s_ff.need_st;
    receive_dma_request_n_o = ~(pin_control_reg_i[`MW_IOC_RECEIVE_DMA_REQUEST] & rx_valid_o);
    transmit_dma_request_n_o = ~(pin_control_reg_i[`MW_IOC_TRANSMIT_DMA_REQUEST] & tx_want);
    tx_data_pin_o = s_ff.txd;
    tx_data_pin_oe_o = pin_control_reg_i[`MW_IOC_TXD];
    transmit_clock_pin_o = (s_ff.tst == TX_IDLE);
    transmit_clock_pin_oe_o = pin_control_reg_i[`MW_IOC_TXC];
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  pol_capture_a: assert property (tx_wr && !s_ff.need_st && tx_room_o |=>
    tx_mem[$past(s_ff.twp[4:0])][8] == $past(s_ff.pol))
    else $error("polarity not stored with byte");
  count_step_a: assert property (tx_wr && !s_ff.need_st && tx_room_o && !tx_wide_i
    && !send_count_load_i && s_ff.cnt != 16'h0 |=> s_ff.cnt == $past(s_ff.cnt) - 16'h1)
    else $error("send counter did not step");
  eof_hold_a: assert property (s_ff.hold |-> transmit_dma_request_n_o)
    else $error("transmit request during end-of-frame hold");
  wait_send_a: assert property (transmit_irq_control_reg_i[`MW_TIC_WAIT] && !s_ff.armed
    && !s_ff.need_st |-> transmit_dma_request_n_o)
    else $error("request without send command");
  idle_flag_a: assert property (s_ff.tst == TX_SEND |-> !transmit_clock_pin_o)
    else $error("complete flag high while sending");
  rx_status_a: assert property (rx_rd && rx_valid_o && rx_mem[s_ff.rrp[4:0]][10] |=>
    receive_command_status_reg_o[`MW_RCS_POL] == $past(rx_mem[s_ff.rrp[4:0]][9]))
    else $error("status polarity not updated");
  rx_tag_a: assert property (rx_push |=> rx_mem[$past(s_ff.rwp[4:0]) + 5'h1][10]
    && !rx_mem[$past(s_ff.rwp[4:0])][10])
    else $error("word end tag misplaced");
  irq_gate_a: assert property (irq_o |-> interrupt_control_reg_i[`MW_ICR_MIE])
    else $error("interrupt without master enable");
  tx_len_a: assert property (s_ff.tst == TX_IDLE ##1 s_ff.tst == TX_SEND |->
    (s_ff.tst == TX_SEND)[*8])
    else $error("word ended too early");
endmodule : mw_channel
`default_nettype wire

// File: src/mw_pkg.sv
// state types of the word serial channel
package mw_pkg;
  typedef enum logic [0:0] {RX_IDLE = 1'b0, RX_WORD = 1'b1} mw_rx_type;
  typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SEND = 1'b1} mw_tx_type;
  typedef struct packed {
    logic [3:0] s1, s2, s3, st;
    logic rxc_d, rl_d;
    mw_rx_type rst;
    logic [4:0] rc, bc;
    logic [7:0] pc;
    logic [16:0] sr;
    logic rpol;
    logic [5:0] rwp, rrp, twp, trp, hn;
    logic [7:0] rdat;
    logic reof, rcs_pol, rcs_pe, ovr, pe_pend, ov_pend;
    mw_tx_type tst;
    logic [2:0] hc;
    logic [39:0] pat;
    logic txd, pol, need_st, st_idx, hold, armed;
    logic [15:0] cnt;
    logic [1:0] order;
  } mw_state_type;
endpackage : mw_pkg

// File: verification/mw_bus_model.sv
// bus transceiver model: free 8x receive clock and manchester words on the receive line
`timescale 1ns/1ps
`default_nettype none
module mw_bus_model (
  // serial side
  output logic rxc_o,
  output logic line_o
);
  // the 8x clock runs free, since the receiver divides it down to recover bits
  initial begin
    rxc_o = 1'b0;
    forever #62.5 rxc_o = ~rxc_o;
  end
  initial line_o = 1'b1;
  // levels change on falling edges, away from the edge the receiver samples on
  task automatic half(input logic v, input int n);
    line_o = v;
    repeat (n) @(negedge rxc_o);
  endtask : half
  // park the line at a level; any edge after a long level starts a word
  task automatic level(input logic v);
    @(negedge rxc_o);
    half(v, 24);
  endtask : level
  task automatic send(input logic pol, input logic [15:0] d, input logic [1:0] ord,
                      input logic bad);
    int   m;
    logic b;
    @(negedge rxc_o);
    half(pol, 24);
    half(~pol, 12);
    for (int k = 0; k < 16; k++) begin
      case (ord)
        2'h0: m = (k + 8) % 16;
        2'h1: m = 15 - k;
        2'h2: m = k;
        default: m = (23 - k) % 16;
      endcase
      b = d[m];
      half(b, 4);
      half(~b, 4);
    end
    b = ~(^d) ^ bad;
    half(b, 4);
    half(~b, 4);
    line_o = pol;
  endtask : send
endmodule : mw_bus_model
`default_nettype wire

// File: verification/mw_channel_bench.sv
// testbench of the word serial channel: model words in, looped-back words out
`timescale 1ns/1ps
`default_nettype none
module mw_channel_bench;
  logic        clk, rst_n, cmr_wr, conn, ocmd, send, ld, iclr, wr, rd, loop, cts_n;
  logic [1:0]  ord;
  logic [15:0] channel_mode_reg, channel_control_reg, receive_mode_reg, tmr, tic, tcs, ric, interrupt_control_reg, hardware_config_reg, ioc, scnt, wdat, rcs;
  logic        room, nsts, rvld, reof, irq, rreq_n, treq_n, txd, txd_oe, tcp, tcp_oe;
  logic        rxc, mline, wide;
  logic [7:0]  rdat;
  int          n_fail = 0, samples_checked = 0, cyc = 0, tgl = 0;

  mw_bus_model mw_bus_model_i (.rxc_o(rxc), .line_o(mline));
  mw_channel mw_channel_i (
    .ref_clk_i(clk), .reset_n_i(rst_n), .channel_mode_reg_i(channel_mode_reg), .channel_mode_wr_i(cmr_wr),
    .channel_control_reg_i(channel_control_reg), .receive_mode_reg_i(receive_mode_reg), .transmit_mode_reg_i(tmr),
    .transmit_irq_control_reg_i(tic), .transmit_command_status_reg_i(tcs),
    .receive_irq_control_reg_i(ric), .interrupt_control_reg_i(interrupt_control_reg),
    .hardware_config_reg_i(hardware_config_reg), .pin_control_reg_i(ioc), .clock_connect_i(conn),
    .order_cmd_i(ocmd), .order_i(ord), .send_cmd_i(send), .send_count_load_i(ld),
    .send_count_i(scnt), .irq_clear_i(iclr), .tx_wr_i(wr), .tx_wide_i(wide),
    .tx_data_i(wdat), .tx_room_o(room), .tx_need_status_o(nsts), .rx_rd_i(rd),
    .rx_valid_o(rvld), .rx_data_o(rdat), .rx_eof_o(reof),
    .receive_command_status_reg_o(rcs), .irq_o(irq), .receive_dma_request_n_o(rreq_n),
    .transmit_dma_request_n_o(treq_n), .receive_dma_acknowledge_n_i(1'b1),
    .transmit_dma_acknowledge_n_i(1'b1), .receive_clock_pin_i(rxc),
    .rx_data_pin_i(loop ? txd : mline), .carrier_detect_n_i(1'b0),
    .clear_to_send_n_i(cts_n), .tx_data_pin_o(txd), .tx_data_pin_oe_o(txd_oe),
    .transmit_clock_pin_o(tcp), .transmit_clock_pin_oe_o(tcp_oe)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(txd) tgl++;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  // one-cycle strobes: mode write, order, send, count load, irq clear
  task automatic pulse(input logic [4:0] s);
    @(negedge clk);
    {cmr_wr, ocmd, send, ld, iclr} = s;
    @(negedge clk);
    {cmr_wr, ocmd, send, ld, iclr} = '0;
  endtask : pulse

  task automatic put(input logic [15:0] d);
    @(negedge clk);
    wr = 1'b1;
    wdat = d;
    @(negedge clk);
    wr = 1'b0;
  endtask : put

  task automatic get(input logic [15:0] exp, input logic pol, input logic pe);
    for (int b = 0; b < 2; b++) begin
      @(negedge clk);
      for (int t = 0; t < 8000 && rvld !== 1'b1; t++) @(negedge clk);
      chk(rreq_n, 1'b0);
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      chk(rdat, b ? exp[15:8] : exp[7:0]);
      chk(reof, b[0]);
    end
    chk(rcs[9:8], {pe, pol});
  endtask : get

  task automatic wait_tc(input logic v);
    for (int t = 0; t < 6000 && tcp !== v; t++) @(negedge clk);
  endtask : wait_tc

  // a hang counts as a mismatch and closes the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      wrap_up();
    end
  end

  initial begin
    {cmr_wr, ocmd, send, ld, iclr, conn, wr, rd, loop, rst_n} = '0;
    {channel_mode_reg, channel_control_reg, receive_mode_reg, tmr, tic, tcs, ric, interrupt_control_reg, hardware_config_reg, ioc, scnt, wdat} = '0;
    ord = 2'h0;
    cts_n = 1'b1;
    wide = 1'b1;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk(tcp, 1'b1);
    chk(rcs, 16'h0000);
    chk(treq_n, 1'b1);
    chk(room, 1'b1);
    hardware_config_reg = 16'h0700;
    channel_mode_reg = 16'h0100;
    ioc = 16'h000f;
    conn = 1'b1;
    receive_mode_reg = 16'h0002;
    // only single-word receive status traffic is used here
    repeat (20) @(negedge clk);
    for (int o = 0; o < 4; o++) begin
      if (o > 0) begin
        ord = o[1:0];
        pulse(5'h08);
      end
      mw_bus_model_i.send(1'b1, 16'h1c35 + 16'(o) * 16'h2222, o[1:0], 1'b0);
      get(16'h1c35 + 16'(o) * 16'h2222, 1'b1, 1'b0);
    end
    ord = 2'h0;
    pulse(5'h08);
    ric = 16'h0010;
    mw_bus_model_i.send(1'b1, 16'h00ff, 2'h0, 1'b1);
    get(16'h00ff, 1'b1, 1'b1);
    chk(irq, 1'b0);
    interrupt_control_reg = 16'h8000;
    @(negedge clk);
    chk(irq, 1'b1);
    pulse(5'h01);
    chk(irq, 1'b0);
    receive_mode_reg = 16'h0000;
    mw_bus_model_i.level(1'b0);
    @(negedge clk);
    receive_mode_reg = 16'h0002;
    mw_bus_model_i.send(1'b0, 16'h6a53, 2'h0, 1'b0);
    get(16'h6a53, 1'b0, 1'b0);
    $display("test receive done");
    // receiver off while the line source switches, so no false word starts
    receive_mode_reg = 16'h0000;
    loop = 1'b1;
    tmr = 16'h0003;
    channel_control_reg = 16'hc000;
    repeat (5) @(negedge clk);
    chk(treq_n, 1'b1);
    cts_n = 1'b0;
    repeat (5) @(negedge clk);
    chk(treq_n, 1'b0);
    tic = 16'h0004;
    @(negedge clk);
    chk(treq_n, 1'b1);
    pulse(5'h04);
    chk(treq_n, 1'b0);
    repeat (400) @(negedge clk);
    receive_mode_reg = 16'h0002;
    channel_mode_reg = 16'h1100;
    pulse(5'h10);
    scnt = 16'h0003;
    pulse(5'h02);
    put(16'h1234);
    chk(treq_n, 1'b0);
    put(16'habcd);
    chk(treq_n, 1'b1);
    chk(nsts, 1'b1);
    wait_tc(1'b0);
    wait_tc(1'b1);
    chk(treq_n, 1'b1);
    wait_tc(1'b0);
    repeat (3) @(negedge clk);
    chk(treq_n, 1'b0);
    put(16'h0000);
    put(16'h0001);
    wide = 1'b0;
    put(16'h000f);
    put(16'h005a);
    wide = 1'b1;
    chk(nsts, 1'b1);
    chk(treq_n, 1'b1);
    get(16'h1234, 1'b1, 1'b0);
    get(16'habcd, 1'b1, 1'b0);
    get(16'h5a0f, 1'b0, 1'b0);
    $display("test transmit done");
    tgl = 0;
    repeat (300) @(negedge clk);
    chk(16'(tgl > 0), 16'h0001);
    tcs = 16'h0100;
    repeat (300) @(negedge clk);
    tgl = 0;
    repeat (300) @(negedge clk);
    chk(16'(tgl), 16'h0000);
    chk(tcp, 1'b1);
    chk({tcp_oe, txd_oe}, 2'h3);
    $display("test idle done");
    wrap_up();
  end
endmodule : mw_channel_bench
`default_nettype wire
